//--- hw/dcc_pkg.sv
// Package of constants and types for the dual comparator control block
package dcc_pkg;

  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CFG_OFS    = 5'h00;
  localparam logic [ADDR_W-1:0] LADDER_OFS = 5'h04;
  localparam logic [ADDR_W-1:0] RESULT_OFS = 5'h08;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 5'h0c;
  localparam logic [ADDR_W-1:0] MASK_OFS   = 5'h10;

  // Configuration word field positions
  localparam int unsigned CFG_EN1_BIT   = 0;
  localparam int unsigned CFG_EN2_BIT   = 1;
  localparam int unsigned CFG_INV1_BIT  = 2;
  localparam int unsigned CFG_INV2_BIT  = 3;
  localparam int unsigned CFG_FLG1_BIT  = 4;
  localparam int unsigned CFG_FLG2_BIT  = 5;
  localparam int unsigned CFG_SRC1_BIT  = 6;
  localparam int unsigned CFG_SRC2_BIT  = 7;
  localparam int unsigned CFG_FIX1_BIT  = 8;
  localparam int unsigned CFG_FIX2_BIT  = 9;
  localparam int unsigned CFG_W         = 10;

  // Reference ladder byte field positions
  localparam int unsigned LAD_EN_BIT    = 7;
  localparam int unsigned LAD_SHORT_BIT = 5;
  localparam int unsigned LAD_TAP_W32   = 5;
  localparam int unsigned LAD_TAP_W16   = 4;
  localparam int unsigned LAD_W         = 8;

  // Bottom resistor is eight units of a 32-unit ladder span
  localparam logic [5:0]  BOTTOM_UNITS  = 6'h08;

  // Status and mask layout
  localparam int unsigned STS_CHG_BIT   = 0;
  localparam int unsigned STS_W         = 1;

  // Reset values
  localparam logic [CFG_W-1:0] CFG_RST  = 10'h000;
  localparam logic [LAD_W-1:0] LAD_RST  = 8'h00;
  localparam logic [STS_W-1:0] STS_RST  = 1'h0;
  localparam logic [STS_W-1:0] MASK_RST = 1'h0;

  typedef struct packed {
    logic fix2;
    logic fix1;
    logic src2;
    logic src1;
    logic flg2;
    logic flg1;
    logic inv2;
    logic inv1;
    logic en2;
    logic en1;
  } dcc_cfg_t;

  typedef struct packed {
    logic       enable;
    logic [5:0] level;
    logic       bottom_short;
  } dcc_ladder_t;

endpackage

//--- hw/dcc_top.sv
// Dual comparator control with a classic Wishbone register slave
//
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/10ps

// Operation
// - Config bits 0,1 enable comparators one, two
// - Config bit 2 inverts comparator one
// - Config bit 3 inverts comparator two
// - Config bits 4,5 gate change flagging
// - Enabled output change sets the flag
// - Result bits 0,1 hold outputs after inversion
// - Change flag can raise an interrupt
// - Enabled change wakes device from sleep
// - Config bit 6 routes comparator one input
// - Config bit 7 routes comparator two input
// - Config bit 8 picks divider or fixed one
// - Config bit 9 picks divider or fixed two
// - Ladder byte bit 7 enables the ladder
// - Wide variant: bits 4:0 pick 32 taps
// - Narrow variant: bits 3:0 pick 16 taps
// - Narrow variant: bit 5 shorts bottom resistor
module dcc_top
  import dcc_pkg::*;
#(
  parameter bit NARROW_LADDER = 1'b0
)
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [DATA_W-1:0] wb_dat_i,
  output logic      [DATA_W-1:0] wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              comp1_raw_i,
  input  wire logic              comp2_raw_i,
  output logic                   comp1_en_o,
  output logic                   comp2_en_o,
  output logic                   comp1_src_internal_o,
  output logic                   comp2_src_internal_o,
  output logic                   comp1_ref_fixed_o,
  output logic                   comp2_ref_fixed_o,
  output logic                   ladder_en_o,
  output logic      [5:0]        ladder_level_o,
  output logic                   ladder_bottom_short_o,
  output logic      [1:0]        result_o,
  output logic                   irq_o,
  output logic                   wake_o
);

  dcc_cfg_t         cfg_reg;
  logic [LAD_W-1:0] lad_reg;
  logic [STS_W-1:0] sts_reg;
  logic [STS_W-1:0] mask_reg;
  logic [1:0]       res_reg;
  logic [1:0]       res_prev_reg;
  logic             ack_reg;
  logic [DATA_W-1:0] rdat_reg;
  logic             irq_reg;
  logic             wake_reg;
  dcc_ladder_t      lad_next;

  logic             bus_req;
  logic             wr_stb;
  logic [1:0]       res_next;
  logic [1:0]       chg;
  logic             chg_event;
  logic [STS_W-1:0] sts_next;
  logic [DATA_W-1:0] rdat_next;

  // A request is taken once; ack drops in the cycle after it was given
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr_stb  = bus_req & wb_we_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= bus_req;
    end
  end

  // Configuration word over byte lanes 0 and 1
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_reg <= dcc_cfg_t'(CFG_RST);
    end
    else if (wr_stb && wb_adr_i == CFG_OFS)
    begin
      if (wb_sel_i[0])
      begin
        cfg_reg[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1])
      begin
        cfg_reg[CFG_W-1:8] <= wb_dat_i[CFG_W-1:8];
      end
    end
  end

  // Ladder byte
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lad_reg <= LAD_RST;
    end
    else if (wr_stb && wb_adr_i == LADDER_OFS && wb_sel_i[0])
    begin
      lad_reg <= wb_dat_i[LAD_W-1:0];
    end
  end

  // Interrupt mask
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mask_reg <= MASK_RST;
    end
    else if (wr_stb && wb_adr_i == MASK_OFS && wb_sel_i[0])
    begin
      mask_reg <= wb_dat_i[STS_W-1:0];
    end
  end

  // Comparator outputs: disabled reads zero, enabled applies inversion
  always_comb
  begin
    res_next[0] = cfg_reg.en1 & (comp1_raw_i ^ cfg_reg.inv1);
    res_next[1] = cfg_reg.en2 & (comp2_raw_i ^ cfg_reg.inv2);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      res_reg      <= 2'h0;
      res_prev_reg <= 2'h0;
    end
    else
    begin
      res_reg      <= res_next;
      res_prev_reg <= res_reg;
    end
  end

  // Change detection, gated per comparator
  assign chg[0]    = (res_reg[0] ^ res_prev_reg[0]) & cfg_reg.flg1;
  assign chg[1]    = (res_reg[1] ^ res_prev_reg[1]) & cfg_reg.flg2;
  assign chg_event = |chg;

  // Sticky flag, write one to clear; a new change wins over the clear
  always_comb
  begin
    sts_next = sts_reg;
    if (wr_stb && wb_adr_i == STATUS_OFS && wb_sel_i[0])
    begin
      sts_next = sts_reg & ~wb_dat_i[STS_W-1:0];
    end
    if (chg_event)
    begin
      sts_next[STS_CHG_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sts_reg <= STS_RST;
    end
    else
    begin
      sts_reg <= sts_next;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_reg  <= 1'b0;
      wake_reg <= 1'b0;
    end
    else
    begin
      irq_reg  <= |(sts_next & mask_reg);
      wake_reg <= chg_event;
    end
  end

  // Ladder level in 32nds of supply
  always_comb
  begin
    lad_next.enable       = lad_reg[LAD_EN_BIT];
    lad_next.bottom_short = 1'b0;
    if (NARROW_LADDER)
    begin
      lad_next.bottom_short = lad_reg[LAD_SHORT_BIT];
      if (lad_reg[LAD_SHORT_BIT])
      begin
        lad_next.level = {2'b00, lad_reg[LAD_TAP_W16-1:0]};
      end
      else
      begin
        lad_next.level = {2'b00, lad_reg[LAD_TAP_W16-1:0]} + BOTTOM_UNITS;
      end
    end
    else
    begin
      lad_next.level = {1'b0, lad_reg[LAD_TAP_W32-1:0]};
    end
  end

  // Analogue control outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      comp1_en_o            <= 1'b0;
      comp2_en_o            <= 1'b0;
      comp1_src_internal_o  <= 1'b0;
      comp2_src_internal_o  <= 1'b0;
      comp1_ref_fixed_o     <= 1'b0;
      comp2_ref_fixed_o     <= 1'b0;
      ladder_en_o           <= 1'b0;
      ladder_level_o        <= 6'h00;
      ladder_bottom_short_o <= 1'b0;
    end
    else
    begin
      comp1_en_o            <= cfg_reg.en1;
      comp2_en_o            <= cfg_reg.en2;
      comp1_src_internal_o  <= cfg_reg.src1;
      comp2_src_internal_o  <= cfg_reg.src2;
      comp1_ref_fixed_o     <= cfg_reg.fix1;
      comp2_ref_fixed_o     <= cfg_reg.fix2;
      ladder_en_o           <= lad_next.enable;
      ladder_level_o        <= lad_next.level;
      ladder_bottom_short_o <= lad_next.bottom_short;
    end
  end

  // Read data; unmapped addresses read zero
  always_comb
  begin
    rdat_next = '0;
    case (wb_adr_i)
      CFG_OFS:    rdat_next[CFG_W-1:0] = cfg_reg;
      LADDER_OFS: rdat_next[LAD_W-1:0] = lad_reg;
      RESULT_OFS: rdat_next[1:0]       = res_reg;
      STATUS_OFS: rdat_next[STS_W-1:0] = sts_reg;
      MASK_OFS:   rdat_next[STS_W-1:0] = mask_reg;
      default:    rdat_next = '0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdat_reg <= '0;
    end
    else if (bus_req)
    begin
      rdat_reg <= rdat_next;
    end
  end

  assign wb_dat_o = rdat_reg;
  assign wb_ack_o = ack_reg;
  assign result_o = res_reg;
  assign irq_o    = irq_reg;
  assign wake_o   = wake_reg;

endmodule

//--- verification/dcc_top_monitor.sv
// Port-level assertions for the dual comparator control block
`timescale 1ns/10ps
module dcc_monitor
#(
  parameter bit NARROW_LADDER = 1'b0
)
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       comp1_en_o,
  input wire logic       comp2_en_o,
  input wire logic       ladder_en_o,
  input wire logic [5:0] ladder_level_o,
  input wire logic       ladder_bottom_short_o,
  input wire logic [1:0] result_o,
  input wire logic       irq_o,
  input wire logic       wake_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_when_taken: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_reset_all_off: assert property ($fell(rst_i) |->
    !comp1_en_o && !comp2_en_o && !ladder_en_o && !irq_o && !wake_o && result_o == 2'h0)
    else $error("outputs not cleared by reset");
  a_off_one_zero: assert property (!comp1_en_o && $past(!comp1_en_o) |-> !result_o[0])
    else $error("disabled comparator one reports high");
  a_off_two_zero: assert property (!comp2_en_o && $past(!comp2_en_o) |-> !result_o[1])
    else $error("disabled comparator two reports high");
  a_wake_on_change: assert property (wake_o |-> $past(result_o) != $past(result_o, 2))
    else $error("wake without result change");
  a_wide_tap_range: assert property (!NARROW_LADDER |->
    !ladder_level_o[5] && !ladder_bottom_short_o)
    else $error("wide ladder level out of range");
  a_bottom_in_use: assert property (NARROW_LADDER && !$past(rst_i) && !ladder_bottom_short_o |->
    ladder_level_o >= 6'h08 && ladder_level_o <= 6'h17)
    else $error("bottom resistor offset missing");
endmodule

bind dcc_top dcc_monitor #(.NARROW_LADDER(NARROW_LADDER)) u_mon (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .comp1_en_o, .comp2_en_o, .ladder_en_o, .ladder_level_o,
  .ladder_bottom_short_o, .result_o, .irq_o, .wake_o);

//--- verification/tb_dcc_top.sv
// Self-checking bench for the dual comparator control block
`timescale 1ns/10ps
module tb_dcc_top import dcc_pkg::*;;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [ADDR_W-1:0] adr = '0;
  logic [DATA_W-1:0] dat = '0, rd, dout;
  logic [1:0]        raw = 2'h0, res, ex;
  logic [5:0]        lvl;
  logic              ack, en1, en2, s1, s2, f1, f2, len, lsh, irq, wake;
  logic [5:0]        lvl_n;
  logic              len_n, lsh_n;
  logic [9:0]        cv [2] = '{10'h281, 10'h142};
  int                miscompares = 0, cmp_count = 0, wake_cnt = 0;

  dcc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(dout),
    .wb_ack_o(ack), .comp1_raw_i(raw[0]), .comp2_raw_i(raw[1]), .comp1_en_o(en1),
    .comp2_en_o(en2), .comp1_src_internal_o(s1), .comp2_src_internal_o(s2),
    .comp1_ref_fixed_o(f1), .comp2_ref_fixed_o(f2), .ladder_en_o(len),
    .ladder_level_o(lvl), .ladder_bottom_short_o(lsh), .result_o(res), .irq_o(irq),
    .wake_o(wake));

  // Sixteen-tap variant shares the bus so both ladders see the same writes
  dcc_top #(.NARROW_LADDER(1'b1)) dut_n (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat),
    .wb_dat_o(), .wb_ack_o(), .comp1_raw_i(raw[0]), .comp2_raw_i(raw[1]), .comp1_en_o(),
    .comp2_en_o(), .comp1_src_internal_o(), .comp2_src_internal_o(),
    .comp1_ref_fixed_o(), .comp2_ref_fixed_o(), .ladder_en_o(len_n),
    .ladder_level_o(lvl_n), .ladder_bottom_short_o(lsh_n), .result_o(), .irq_o(),
    .wake_o());

  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) if (wake === 1'b1) wake_cnt++;

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clk_i);
  endtask

  // One classic cycle; ack is sampled before the edge's own updates land
  task automatic wb(logic w, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1)
      miscompares++;
    rd = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    tick(2);
    rst_i <= 1'b0;
    chk("outs", {s1, s2, f1, f2, lsh, en1, en2, len, lvl, irq, wake, res}, 32'h0);
    chk("outs_n", {lsh_n, len_n, lvl_n}, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      wb(1'b0, 5'(4 * i), 32'h0);
      chk("rst_rd", rd, 32'h0);
    end
    foreach (cv[i])
    begin
      wb(1'b1, CFG_OFS, 32'(cv[i]));
      tick(2);
      chk("cfg", {f2, f1, s2, s1, en2, en1}, {cv[i][9:6], cv[i][1:0]});
      wb(1'b0, CFG_OFS, 32'h0);
      chk("cfg_rd", rd, 32'(cv[i]));
    end
    for (int k = 0; k < 8; k++)
    begin
      wb(1'b1, CFG_OFS, k[2] ? 32'h00f : 32'h003);
      raw <= k[1:0];
      tick(3);
      ex = k[1:0] ^ {2{k[2]}};
      chk("res", res, ex);
      wb(1'b0, RESULT_OFS, 32'h0);
      chk("res_rd", rd, ex);
    end
    wb(1'b1, CFG_OFS, 32'h00c);
    tick(3);
    chk("res_off", res, 32'h0);
    raw <= 2'h0;
    wb(1'b1, CFG_OFS, 32'h003);
    wb(1'b1, CFG_OFS, 32'h013);
    wb(1'b1, STATUS_OFS, 32'h1);
    tick(2);
    wake_cnt = 0;
    raw <= 2'h2;
    tick(4);
    wb(1'b0, STATUS_OFS, 32'h0);
    chk("flag_off", rd, 32'h0);
    chk("wake_off", wake_cnt, 32'h0);
    raw <= 2'h3;
    tick(6);
    wb(1'b0, STATUS_OFS, 32'h0);
    chk("flag_on", rd, 32'h1);
    chk("wake_on", wake_cnt, 32'h1);
    chk("irq_mask", irq, 32'h0);
    wb(1'b1, MASK_OFS, 32'h1);
    tick(2);
    chk("irq_on", irq, 32'h1);
    wb(1'b1, STATUS_OFS, 32'h1);
    tick(2);
    chk("irq_clr", irq, 32'h0);
    wb(1'b1, LADDER_OFS, 32'h09f);
    tick(2);
    chk("lad_hi", {lsh, len, lvl}, 32'h5f);
    chk("lad_n_hi", {lsh_n, len_n, lvl_n}, 32'h57);
    wb(1'b1, LADDER_OFS, 32'h005);
    tick(2);
    chk("lad_lo", {lsh, len, lvl}, 32'h05);
    chk("lad_n_lo", {lsh_n, len_n, lvl_n}, 32'h0d);
    wb(1'b1, LADDER_OFS, 32'h0a3);
    tick(2);
    chk("lad_sh", {lsh, len, lvl}, 32'h43);
    chk("lad_n_sh", {lsh_n, len_n, lvl_n}, 32'hc3);
    report_and_stop();
  end

  initial
  begin
    tick(3000);
    miscompares++;
    report_and_stop();
  end
endmodule
